//--- core/sacs_regs.vh
`ifndef SACS_REGS_VH
`define SACS_REGS_VH
// converter geometry
`define SACS_RES_BITS       12
`define SACS_OFS_BITS       8
// trial code loaded at conversion start (octal 4000)
`define SACS_TRIAL_INIT     12'h800
// offset-binary zero for the fine offset dac
`define SACS_OFS_RST        8'h80
// settling times in ns and derived cycle counts at 200 MHz
`define SACS_CLK_MHZ        200
`define SACS_HOLD_NS        50
`define SACS_HOLD_CYC       ((`SACS_HOLD_NS * `SACS_CLK_MHZ + 999) / 1000)
`define SACS_TRIAL_NS       100
`define SACS_TRIAL_CYC      ((`SACS_TRIAL_NS * `SACS_CLK_MHZ + 999) / 1000)
// data buffer field layout
`define SACS_RES_LSB        0
`define SACS_OFS_LSB        0
`define SACS_DATA_BITS      16
`endif

//--- core/sacs_timer.v
`timescale 1ns/1ps
// interval timer: pulses done after len cycles from a start pulse
module sacs_timer #(
	parameter W = 8
) (
	// clock and reset
	input  wire         mclk,
	input  wire         rst_n,
	input  wire         ce,
	// control
	input  wire         start,
	input  wire [W-1:0] len,
	// status
	output reg          done
);
	reg [W-1:0] cnt_q;
	reg         run_q;

	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= {W{1'b0}};
			run_q <= 1'b0;
			done  <= 1'b0;
		end else if (ce) begin
			done <= 1'b0;
			if (start) begin
				cnt_q <= len;
				run_q <= 1'b1;
			end else if (run_q) begin
				if (cnt_q <= {{(W-1){1'b0}}, 1'b1}) begin
					run_q <= 1'b0;
					done  <= 1'b1;
				end else begin
					cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
				end
			end
		end
	end
endmodule // sacs_timer

//--- core/sacs_sar.v
`timescale 1ns/1ps
`include "sacs_regs.vh"
// successive-approximation register with a walking trial pointer
module sacs_sar #(
	parameter N = `SACS_RES_BITS
) (
	// clock and reset
	input  wire         mclk,
	input  wire         rst_n,
	input  wire         ce,
	// control
	input  wire         load,
	input  wire         decide,
	input  wire         cmp_pos,
	// state
	output reg  [N-1:0] code,
	output reg  [N-1:0] ptr,
	output wire         last
);
	assign last = ptr[0];

	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			code <= {N{1'b0}};
			ptr  <= {N{1'b0}};
		end else if (ce) begin
			if (load) begin
				code <= `SACS_TRIAL_INIT;
				ptr  <= `SACS_TRIAL_INIT;
			end else if (decide) begin
				if (cmp_pos)
					code <= (code & ~ptr) | (ptr >> 1);
				else
					code <= code | (ptr >> 1);
				ptr <= ptr >> 1;
			end
		end
	end
endmodule // sacs_sar

//--- core/sacs_seq.v
`timescale 1ns/1ps
`include "sacs_regs.vh"

// Notes on behaviour
// - trial code starts at octal 4000
// - trial bits msb first down to lsb
// - latch comparator decision each trial end
// - positive summing node clears trial bit
// - after lsb copy sar to buffer
// - sample phase: preamp drives sample-hold
// - at start, hold then route to comparator
// - then negative channel or auto-zero ground
// - write-only offset field drives fine dac
// - offset field is 8-bit offset binary
// - offset code steady through conversion
// - sample phase enables addressed channel
// - single-ended hold: channels off, zero on
module sacs_seq #(
	parameter NCH   = 16,
	parameter CHW   = 4,
	parameter HOLDC = `SACS_HOLD_CYC,
	parameter TRIC  = `SACS_TRIAL_CYC
) (
	// clock and reset
	input  wire                       mclk,
	input  wire                       rst_n,
	input  wire                       ce,
	// software side
	input  wire                       start,
	input  wire [CHW-1:0]             chan_sel,
	input  wire                       single_ended_input,
	input  wire                       ofs_wr,
	input  wire [`SACS_DATA_BITS-1:0] wr_data,
	input  wire                       result_rd,
	output reg  [`SACS_DATA_BITS-1:0] data_buf_q,
	output reg                        done_q,
	output reg                        busy_q,
	// analog side
	input  wire                       cmp_pos,
	output reg  [`SACS_RES_BITS-1:0]  fb_dac_q,
	output reg  [`SACS_OFS_BITS-1:0]  ofs_dac_q,
	output reg                        track_q,
	output reg                        cmp_route_q,
	output reg  [NCH-1:0]             mux_en_q,
	output reg                        azero_q
);
	localparam S_IDLE  = 4'b0001;
	localparam S_HOLD  = 4'b0010;
	localparam S_TRIAL = 4'b0100;
	localparam S_DONE  = 4'b1000;

	reg  [3:0]                 st_q;
	reg  [3:0]                 st_d;
	reg  [`SACS_OFS_BITS-1:0]  ofs_shadow_q;
	reg  [CHW-1:0]             chan_q;
	reg                        se_q;
	reg                        tmr_start;
	reg  [7:0]                 tmr_len;
	wire                       tmr_done;
	wire [`SACS_RES_BITS-1:0]  code;
	wire [`SACS_RES_BITS-1:0]  ptr;
	wire                       last;
	wire                       sar_load;
	wire                       sar_decide;
	wire                       take_start;
	wire                       se_now;
	wire [CHW-1:0]             chan_now;
	wire [`SACS_OFS_BITS-1:0]  ofs_in;
	reg  [`SACS_OFS_BITS-1:0]  ofs_shadow_d;
	reg  [`SACS_OFS_BITS-1:0]  ofs_dac_d;
	reg  [CHW-1:0]             chan_d;
	reg                        se_d;
	reg  [`SACS_DATA_BITS-1:0] data_buf_d;
	reg                        done_d;
	reg                        busy_d;
	reg  [`SACS_RES_BITS-1:0]  fb_dac_d;
	reg                        track_d;
	reg                        cmp_route_d;
	reg  [NCH-1:0]             mux_en_d;
	reg                        azero_d;

	// one-hot decode of a channel number
	function [NCH-1:0] chan_hot;
		input [CHW-1:0] c;
		begin
			chan_hot = {{(NCH-1){1'b0}}, 1'b1} << c;
		end
	endfunction

	// pair partner for quasi-differential hold: channel number with its msb flipped, in the other half of the mux
	function [NCH-1:0] neg_hot;
		input [CHW-1:0] c;
		begin
			neg_hot = chan_hot(c ^ {1'b1, {(CHW-1){1'b0}}});
		end
	endfunction

	// fine offset field of a software write
	function [`SACS_OFS_BITS-1:0] ofs_field;
		input [`SACS_DATA_BITS-1:0] w;
		begin
			ofs_field = w[`SACS_OFS_LSB +: `SACS_OFS_BITS];
		end
	endfunction

	assign sar_load   = (st_q == S_HOLD) && tmr_done;
	assign sar_decide = (st_q == S_TRIAL) && tmr_done;
	assign take_start = (st_q == S_IDLE) && start;
	// mode and channel of the conversion being entered or running
	assign se_now     = take_start ? single_ended_input : se_q;
	assign chan_now   = take_start ? chan_sel : chan_q;
	assign ofs_in     = ofs_field(wr_data);

	sacs_timer #(
		.W(8)
	) u_tmr (
		.mclk  (mclk),
		.rst_n (rst_n),
		.ce    (ce),
		.start (tmr_start),
		.len   (tmr_len),
		.done  (tmr_done)
	);

	sacs_sar #(
		.N(`SACS_RES_BITS)
	) u_sar (
		.mclk    (mclk),
		.rst_n   (rst_n),
		.ce      (ce),
		.load    (sar_load),
		.decide  (sar_decide),
		.cmp_pos (cmp_pos),
		.code    (code),
		.ptr     (ptr),
		.last    (last)
	);

	// next state and timer kicks
	always @* begin
		st_d      = st_q;
		tmr_start = 1'b0;
		tmr_len   = 8'h00;
		case (st_q)
		S_IDLE: begin
			if (start) begin
				st_d      = S_HOLD;
				tmr_start = 1'b1;
				tmr_len   = HOLDC[7:0];
			end
		end
		S_HOLD: begin
			if (tmr_done) begin
				st_d      = S_TRIAL;
				tmr_start = 1'b1;
				tmr_len   = TRIC[7:0];
			end
		end
		S_TRIAL: begin
			if (tmr_done) begin
				if (last) begin
					st_d = S_DONE;
				end else begin
					tmr_start = 1'b1;
					tmr_len   = TRIC[7:0];
				end
			end
		end
		S_DONE: begin
			st_d = S_IDLE;
		end
		default: begin
			st_d = S_IDLE;
		end
		endcase
	end

	// next values of the registered outputs
	always @* begin
		ofs_shadow_d = ofs_shadow_q;
		ofs_dac_d    = ofs_dac_q;
		chan_d       = chan_q;
		se_d         = se_q;
		data_buf_d   = data_buf_q;
		done_d       = done_q;
		fb_dac_d     = fb_dac_q;
		busy_d       = (st_d != S_IDLE);
		track_d      = (st_d == S_IDLE);
		cmp_route_d  = (st_d != S_IDLE);
		mux_en_d     = mux_en_q;
		azero_d      = azero_q;
		// fine offset write, never read back
		if (ofs_wr) begin
			ofs_shadow_d = ofs_in;
		end
		if (st_q == S_IDLE && !start) begin
			ofs_dac_d = ofs_wr ? ofs_in : ofs_shadow_q;
		end
		if (take_start) begin
			chan_d = chan_sel;
			se_d   = single_ended_input;
		end
		case (st_d)
		S_IDLE: begin
			mux_en_d = chan_hot(chan_sel);
			azero_d  = 1'b0;
		end
		default: begin
			if (se_now) begin
				mux_en_d = {NCH{1'b0}};
				azero_d  = 1'b1;
			end else begin
				mux_en_d = neg_hot(chan_now);
				azero_d  = 1'b0;
			end
		end
		endcase
		if (sar_load) begin
			fb_dac_d = `SACS_TRIAL_INIT;
		end else if (st_q == S_TRIAL) begin
			fb_dac_d = code;
		end
		// result in low bits, upper zero
		if (st_q == S_DONE) begin
			data_buf_d = {{(`SACS_DATA_BITS-`SACS_RES_BITS){1'b0}}, code};
		end
		if (st_q == S_DONE) begin
			done_d = 1'b1;
		end else if (result_rd || take_start) begin
			done_d = 1'b0;
		end
	end

	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= S_IDLE;
		end else if (ce) begin
			st_q <= st_d;
		end
	end

	// shadow keeps a mid-conversion write for the next idle cycle
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			ofs_shadow_q <= `SACS_OFS_RST;
			ofs_dac_q    <= `SACS_OFS_RST;
		end else if (ce) begin
			ofs_shadow_q <= ofs_shadow_d;
			ofs_dac_q    <= ofs_dac_d;
		end
	end

	// mode latched at start so live inputs cannot disturb a conversion
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			chan_q <= {CHW{1'b0}};
			se_q   <= 1'b0;
		end else if (ce) begin
			chan_q <= chan_d;
			se_q   <= se_d;
		end
	end

	// switches follow the next state, so they move together with busy
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			busy_q      <= 1'b0;
			track_q     <= 1'b1;
			cmp_route_q <= 1'b0;
			mux_en_q    <= {NCH{1'b0}};
			azero_q     <= 1'b0;
		end else if (ce) begin
			busy_q      <= busy_d;
			track_q     <= track_d;
			cmp_route_q <= cmp_route_d;
			mux_en_q    <= mux_en_d;
			azero_q     <= azero_d;
		end
	end

	// fb dac lags the sar code by one cycle; trials must allow for it
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			data_buf_q <= {`SACS_DATA_BITS{1'b0}};
			done_q     <= 1'b0;
			fb_dac_q   <= {`SACS_RES_BITS{1'b0}};
		end else if (ce) begin
			data_buf_q <= data_buf_d;
			done_q     <= done_d;
			fb_dac_q   <= fb_dac_d;
		end
	end
endmodule // sacs_seq

//--- bench/sacs_seq_monitor.sv
`timescale 1ns/1ps
module sacs_seq_monitor (
	// clock and reset
	input wire        mclk,
	input wire        rst_n,
	input wire        ce,
	// software side
	input wire        start,
	input wire [3:0]  chan_sel,
	input wire        single_ended_input,
	input wire        result_rd,
	input wire        done_q,
	input wire        busy_q,
	// analog side
	input wire [11:0] fb_dac_q,
	input wire [7:0]  ofs_dac_q,
	input wire        track_q,
	input wire        cmp_route_q,
	input wire [15:0] mux_en_q,
	input wire        azero_q
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	property p_go; start && ce && !busy_q |=> busy_q && !track_q && cmp_route_q; endproperty
	a_go: assert property (p_go) else $error("start not taken");
	property p_trk; !busy_q |-> track_q && !cmp_route_q; endproperty
	a_trk: assert property (p_trk) else $error("idle not tracking");
	property p_se; $rose(busy_q) && $past(single_ended_input) |-> azero_q && mux_en_q == 16'h0;
	endproperty
	a_se: assert property (p_se) else $error("bad single-ended hold");
	property p_qd; $rose(busy_q) && !$past(single_ended_input)
		|-> !azero_q && mux_en_q == 16'h1 << ($past(chan_sel) ^ 4'h8); endproperty
	a_qd: assert property (p_qd) else $error("bad negative leg");
	property p_idle; !busy_q && $past(!busy_q && rst_n && ce)
		|-> mux_en_q == 16'h1 << $past(chan_sel); endproperty
	a_idle: assert property (p_idle) else $error("bad idle channel");
	property p_init; $rose(busy_q) |-> ##[0:40] fb_dac_q == 12'h800; endproperty
	a_init: assert property (p_init) else $error("no mid-scale trial");
	property p_clr; (result_rd || start) && ce && !busy_q |=> !done_q; endproperty
	a_clr: assert property (p_clr) else $error("done not cleared");
	property p_hold; busy_q && $past(busy_q) |-> $stable(ofs_dac_q); endproperty
	a_hold: assert property (p_hold) else $error("offset moved");
	c_se: cover property ($rose(busy_q) && $past(single_ended_input));
	c_qd: cover property ($rose(busy_q) && !$past(single_ended_input));
	c_rd: cover property (result_rd && done_q);
endmodule // sacs_seq_monitor

bind sacs_seq sacs_seq_monitor sacs_seq_monitor_inst (.mclk(mclk), .rst_n(rst_n), .ce(ce),
	.start(start), .chan_sel(chan_sel), .single_ended_input(single_ended_input),
	.result_rd(result_rd), .done_q(done_q), .busy_q(busy_q), .fb_dac_q(fb_dac_q),
	.ofs_dac_q(ofs_dac_q), .track_q(track_q), .cmp_route_q(cmp_route_q),
	.mux_en_q(mux_en_q), .azero_q(azero_q));

//--- bench/sacs_cmp_model.sv
`timescale 1ns/1ps
// comparator with a cycle of settling, so a trial must last two cycles at least
module sacs_cmp_model (
	// clock
	input  wire        mclk,
	// analog stand-ins
	input  wire [11:0] fb_dac_q,
	input  wire [11:0] level,
	output reg         cmp_pos
);
	initial cmp_pos = 1'b0;
	always @(posedge mclk) begin
		cmp_pos <= fb_dac_q > level;
	end
endmodule // sacs_cmp_model

//--- bench/sar_adc_conversion_sequencer_tb_top.sv
`timescale 1ns/1ps
module sar_adc_conversion_sequencer_tb_top;
	reg         mclk, rst_n, start, single_ended_input, ofs_wr, result_rd;
	reg  [3:0]  chan_sel;
	reg  [15:0] wr_data;
	reg  [11:0] level;
	reg  [31:0] r;
	reg         ce;
	wire [15:0] data_buf_q, mux_en_q;
	wire [11:0] fb_dac_q;
	wire [7:0]  ofs_dac_q;
	wire        done_q, busy_q, cmp_pos, track_q, cmp_route_q, azero_q;
	integer     seed, fail_count, comparisons, k;

	sacs_seq #(.HOLDC(2), .TRIC(2)) sacs_seq_inst (.mclk(mclk), .rst_n(rst_n), .ce(ce),
		.start(start), .chan_sel(chan_sel), .single_ended_input(single_ended_input),
		.ofs_wr(ofs_wr), .wr_data(wr_data), .result_rd(result_rd), .data_buf_q(data_buf_q),
		.done_q(done_q), .busy_q(busy_q), .cmp_pos(cmp_pos), .fb_dac_q(fb_dac_q),
		.ofs_dac_q(ofs_dac_q), .track_q(track_q), .cmp_route_q(cmp_route_q),
		.mux_en_q(mux_en_q), .azero_q(azero_q));
	sacs_cmp_model sacs_cmp_model_inst (.mclk(mclk), .fb_dac_q(fb_dac_q), .level(level),
		.cmp_pos(cmp_pos));

	// expected result: trial each bit msb first, drop it when the node goes positive
	function [15:0] sar_ref(input [11:0] lvl);
		integer b;
		reg [11:0] c;
		begin
			c = 12'h000;
			for (b = 11; b >= 0; b = b - 1) begin
				c[b] = 1'b1;
				if (c > lvl)
					c[b] = 1'b0;
			end
			sar_ref = {4'h0, c};
		end
	endfunction

	task chk(input [15:0] seen, input [15:0] exp);
		begin
			comparisons = comparisons + 1;
			if (seen !== exp) begin
				fail_count = fail_count + 1;
				$display("wrong value at %0t: saw %h, want %h", $time, seen, exp);
			end
		end
	endtask

	task conclude;
		begin
			$display("comparisons %0d fail_count %0d", comparisons, fail_count);
			if (fail_count == 0 && comparisons > 0)
				$display("ALL TESTS PASSED");
			else
				$display("TESTS FAILED");
			$finish;
		end
	endtask

	// one conversion against an input level; w also writes the offset mid-run
	task conv(input [11:0] t, input s, input [3:0] c, input w);
		integer n;
		reg [11:0] f;
		begin
			@(posedge mclk);
			level <= t;
			single_ended_input <= s;
			chan_sel <= c;
			start <= 1'b1;
			@(posedge mclk);
			start <= 1'b0;
			ofs_wr <= w;
			wr_data <= 16'hFF3C;
			@(posedge mclk);
			ofs_wr <= 1'b0;
			if (w) begin
				// freeze mid-trial: the fb dac may not move while the enable is low, and busy stays high
				repeat (4) @(posedge mclk);
				ce <= 1'b0;
				@(negedge mclk);
				f = fb_dac_q;
				repeat (5) @(posedge mclk);
				ce <= 1'b1;
				@(negedge mclk);
				chk(fb_dac_q, f);
				chk(busy_q, 1'b1);
			end
			n = 0;
			while (done_q !== 1'b1 && n < 200) begin
				@(negedge mclk);
				n = n + 1;
			end
			if (n == 200) begin
				fail_count = fail_count + 1;
				conclude;
			end
			chk(data_buf_q, sar_ref(t));
			chk(data_buf_q[15:12], 4'h0);
			chk(done_q, 1'b1);
			@(posedge mclk);
			result_rd <= 1'b1;
			@(posedge mclk);
			result_rd <= 1'b0;
			@(negedge mclk);
			chk(done_q, 1'b0);
			if (w)
				chk(ofs_dac_q, 8'h3C);
			$display("conversion of %h ended", t);
		end
	endtask

	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end

	initial begin
		seed = 66;
		fail_count = 0;
		comparisons = 0;
		rst_n = 1'b0;
		start = 1'b0;
		single_ended_input = 1'b0;
		ofs_wr = 1'b0;
		ce = 1'b1;
		result_rd = 1'b0;
		chan_sel = 4'h0;
		wr_data = 16'h0000;
		level = 12'h000;
		repeat (6) @(posedge mclk);
		rst_n <= 1'b1;
		@(negedge mclk);
		chk(ofs_dac_q, 8'h80);
		chk(track_q, 1'b1);
		@(posedge mclk);
		ofs_wr <= 1'b1;
		wr_data <= 16'h12A5;
		@(posedge mclk);
		ofs_wr <= 1'b0;
		@(negedge mclk);
		chk(ofs_dac_q, 8'hA5);
		chk(data_buf_q, 16'h0000);
		$display("offset write ended");
		conv(12'h000, 1'b0, 4'h3, 1'b0);
		conv(12'hFFF, 1'b1, 4'hF, 1'b1);
		conv(12'h800, 1'b0, 4'h8, 1'b0);
		conv(12'h7FF, 1'b1, 4'h0, 1'b1);
		for (k = 0; k < 8; k = k + 1) begin
			r = $random(seed);
			conv(r[11:0], r[12], r[16:13], r[17]);
		end
		conclude;
	end
endmodule // sar_adc_conversion_sequencer_tb_top
